// File: include/lmf_pkg.sv
package lmf_pkg;

	// verdict of the link monitor
	typedef enum logic [1:0] {LMF_FAIL, LMF_READY, LMF_OK} lmf_verdict_e;

	// link status as seen by the client and auto-negotiation
	typedef struct packed {
		lmf_verdict_e verdict;
		logic faulting;
	} lmf_link_s;

	// fault indication pattern
	localparam int FAULT_RUN_LENGTH = 84;
	localparam int FAULT_CYCLE_THRESHOLD = 3;
	localparam int ONES_W = 7;
	localparam int CYC_W = 2;
	localparam logic [ONES_W-1:0] RUN_MAX = ONES_W'(FAULT_RUN_LENGTH);
	localparam logic [CYC_W-1:0] CYC_MAX = CYC_W'(FAULT_CYCLE_THRESHOLD);

	// qualification interval, allowed 330 to 1000 us
	localparam int CLK_MHZ = 25;
	localparam int STAB_TIME_US = 500;
	localparam int STAB_CYCLES = STAB_TIME_US * CLK_MHZ;
	localparam int TIMER_W = 16;

	// register map (byte addresses)
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] STATUS_OFS = 12'h004;

	// control fields
	localparam int CTRL_AN_PRESENT = 0;
	localparam int CTRL_LINK_ENABLE = 1;
	localparam int CTRL_FEF_ENABLE = 2;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
	localparam logic [31:0] CTRL_MASK = 32'h0000_0007;

	// status fields
	localparam int STAT_VERDICT_LO = 0;
	localparam int STAT_FAULTING = 2;
	localparam int STAT_SIGNAL = 3;
	localparam int STAT_CYC_LO = 4;
	localparam int STAT_ONES_LO = 8;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'h0;

endpackage

// File: rtl/lmf_link_monitor.sv
// Design decisions made here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ns
// Function
// R01: fail on signal off or gate disabled
// R02: qualify signal continuously on for interval
// R03: after qualification verdict goes to ready
// R04: gate enable advances ready to ok
// R05: no auto-negotiation means gate always enabled
// R06: signal on passes transmit bits unchanged
// R07: signal off sends 84 ones, one zero
// R08: count ones run and completed fault cycles
// R09: detector never alters receive data path
// R10: fault declared after three consecutive cycles
// R11: first cycle may exceed 84 ones
// R12: one transmit bit every clock, no gaps
// R13: transceiver delivers continuous receive bits
// R14: received bit treated zero while signal off
// R15: transceiver reports signal quality changes
// R16: fault forces fail, absent feature never faults
// R17: cycle count clears on disqualify, max three
// R18: ones count clears on zero, max 84
// R19: signal drop restarts the qualification timer
// R20: fault flag releases when stream disqualifies
module lmf_link_monitor
	import lmf_pkg::*;
#(
	parameter int STAB_COUNT = STAB_CYCLES
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic signal_ok_pin,
	input wire logic rx_bit_pin,
	input wire logic tx_bit_in,
	output logic tx_bit_out,
	output logic rx_bit_out,
	output lmf_link_s link_status
);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic sig_s1_reg;
	logic sig_s2_reg;
	logic rx_s1_reg;
	logic rx_s2_reg;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sig_s1_reg <= 1'h0;
			sig_s2_reg <= 1'h0;
			rx_s1_reg <= 1'h0;
			rx_s2_reg <= 1'h0;
		end
		else
		begin
			sig_s1_reg <= signal_ok_pin;
			sig_s2_reg <= sig_s1_reg;
			rx_s1_reg <= rx_bit_pin;
			rx_s2_reg <= rx_s1_reg;
		end
	end

	logic sig_ok;
	logic rx_eff;
	assign sig_ok = sig_s2_reg;
	assign rx_eff = rx_s2_reg & sig_ok; // R14

	////////////////////////////////////////////////////////////////////////
	// register bus

	logic [31:0] ctrl_reg;
	logic wr_pend_reg;
	logic rd_ctrl_next;
	logic addr_ok;
	logic an_present;
	logic gate_en;
	logic fef_en;

	assign hreadyout = 1'h1;
	assign hresp = HRESP_OKAY;
	assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ);
	assign an_present = ctrl_reg[CTRL_AN_PRESENT];
	assign gate_en = !an_present || ctrl_reg[CTRL_LINK_ENABLE]; // R05
	assign fef_en = ctrl_reg[CTRL_FEF_ENABLE];
	assign rd_ctrl_next = haddr[11:0] == CTRL_OFS;

	// only the control word is writable; hsize is ignored, whole words only
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			wr_pend_reg <= 1'h0;
		else
			wr_pend_reg <= addr_ok && hwrite && rd_ctrl_next;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ctrl_reg <= CTRL_RESET;
		else if (wr_pend_reg)
			ctrl_reg <= hwdata & CTRL_MASK;
	end

	logic [6:0] ones_reg;
	logic [1:0] cyc_reg;
	logic faulting_reg;
	lmf_verdict_e verdict_reg;
	logic [31:0] status_word;

	always_comb
	begin
		status_word = 32'h0000_0000;
		status_word[STAT_VERDICT_LO +: 2] = verdict_reg;
		status_word[STAT_FAULTING] = faulting_reg;
		status_word[STAT_SIGNAL] = sig_ok;
		status_word[STAT_CYC_LO +: CYC_W] = cyc_reg;
		status_word[STAT_ONES_LO +: ONES_W] = ones_reg;
	end

	// read data sampled at the address phase: zero wait states
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (addr_ok && !hwrite)
		begin
			if (rd_ctrl_next)
				hrdata <= ctrl_reg;
			else if (haddr[11:0] == STATUS_OFS)
				hrdata <= status_word;
			else
				hrdata <= 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// fault generator

	logic [6:0] gen_cnt_reg;
	logic gen_mode;
	assign gen_mode = fef_en && !sig_ok;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			gen_cnt_reg <= 7'h00;
		else if (!gen_mode || gen_cnt_reg == RUN_MAX)
			gen_cnt_reg <= 7'h00;
		else
			gen_cnt_reg <= gen_cnt_reg + 7'h01; // R07
	end

	// one bit leaves every clock, never held back
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			tx_bit_out <= 1'h0;
		else if (!gen_mode)
			tx_bit_out <= tx_bit_in; // R06 R12
		else
			tx_bit_out <= gen_cnt_reg != RUN_MAX; // R07
	end

	////////////////////////////////////////////////////////////////////////
	// fault detector, passive tap on the receive path

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rx_bit_out <= 1'h0;
		else
			rx_bit_out <= rx_s2_reg; // R09
	end

	logic over_reg;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ones_reg <= 7'h00;
		else if (!rx_eff)
			ones_reg <= 7'h00; // R18
		else if (ones_reg != RUN_MAX)
			ones_reg <= ones_reg + 7'h01; // R08
	end

	// a run longer than 84 only counts when it opens the sequence
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			over_reg <= 1'h0;
		else if (!rx_eff)
			over_reg <= 1'h0;
		else if (ones_reg == RUN_MAX)
			over_reg <= 1'h1; // R11
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cyc_reg <= 2'h0;
		else if (rx_eff)
		begin
			if (ones_reg == RUN_MAX && cyc_reg != 2'h0)
				cyc_reg <= 2'h0; // R17
		end
		else if (ones_reg == RUN_MAX && !over_reg)
		begin
			if (cyc_reg != CYC_MAX)
				cyc_reg <= cyc_reg + 2'h1; // R08 R10
		end
		else if (ones_reg == RUN_MAX && cyc_reg == 2'h0)
			cyc_reg <= 2'h1; // R11
		else
			cyc_reg <= 2'h0; // R17
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			faulting_reg <= 1'h0;
		else
			faulting_reg <= fef_en && cyc_reg == CYC_MAX; // R10 R16 R20
	end

	////////////////////////////////////////////////////////////////////////
	// link monitor

	logic [TIMER_W-1:0] timer_reg;
	logic force_fail;
	assign force_fail = !sig_ok || !gate_en || faulting_reg; // R01 R16

	// timer needs an unbroken run of signal on
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			timer_reg <= '0;
		else if (!sig_ok || verdict_reg != LMF_FAIL)
			timer_reg <= '0; // R19
		else if (timer_reg != TIMER_W'(STAB_COUNT - 1))
			timer_reg <= timer_reg + 1'b1; // R02
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			verdict_reg <= LMF_FAIL;
		else if (force_fail)
			verdict_reg <= LMF_FAIL; // R01
		else
		begin
			case (verdict_reg)
				LMF_FAIL:
					if (timer_reg == TIMER_W'(STAB_COUNT - 1))
						verdict_reg <= LMF_READY; // R03
				LMF_READY:
					verdict_reg <= LMF_OK; // R04
				default:
					verdict_reg <= LMF_OK;
			endcase
		end
	end

	assign link_status = '{verdict: verdict_reg, faulting: faulting_reg};

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	chk_sig_off_fail: assert property (!sig_ok |=> verdict_reg == LMF_FAIL) // R01
		else $error("signal off did not force fail");
	chk_gate_fail: assert property (!gate_en |=> verdict_reg == LMF_FAIL) // R01
		else $error("disabled gate did not force fail");
	chk_ready_timed: assert property (
		$rose(verdict_reg == LMF_READY) |-> $past(timer_reg) == TIMER_W'(STAB_COUNT - 1)) // R02
		else $error("ready reached before the full interval");
	chk_ready_to_ok: assert property (
		verdict_reg == LMF_READY && !force_fail |=> verdict_reg == LMF_OK) // R04
		else $error("ready did not advance to ok");
	chk_tx_pass: assert property (!gen_mode |=> tx_bit_out == $past(tx_bit_in)) // R06
		else $error("transmit bit altered while signal on");
	chk_fault_zero: assert property (
		gen_mode && gen_cnt_reg == RUN_MAX ##1 gen_mode |-> !tx_bit_out ##1 tx_bit_out) // R07
		else $error("fault cycle zero misplaced");
	chk_count_limits: assert property (ones_reg <= RUN_MAX && cyc_reg <= CYC_MAX) // R17
		else $error("detector count out of range");
	chk_zero_clear: assert property (!rx_eff |=> ones_reg == 7'h00) // R18
		else $error("ones run not cleared by zero");
	chk_fault_flag: assert property (
		fef_en && cyc_reg == CYC_MAX |=> faulting_reg ##1 verdict_reg == LMF_FAIL) // R10
		else $error("fault not declared or not forcing fail");
	chk_rx_pass: assert property (rx_bit_out == $past(rx_s2_reg)) // R09
		else $error("receive path altered");

	cov_link_ok: cover property ($rose(verdict_reg == LMF_OK));
	cov_fault_seen: cover property ($rose(faulting_reg));
	cov_fault_gen: cover property (gen_mode && gen_cnt_reg == RUN_MAX);

endmodule

// File: tb/lmf_xcvr_model.sv
`timescale 1ns/1ns
module lmf_xcvr_model
	import lmf_pkg::*;
(
	input wire logic hclk,
	input wire logic sig_on,
	input wire logic fef_mode,
	input wire logic data_bit,
	output logic signal_ok_pin,
	output logic rx_bit_pin
);
	logic [ONES_W-1:0] run_reg = 7'h00;
	always @(posedge hclk)
	begin
		run_reg <= (!fef_mode || run_reg == RUN_MAX) ? 7'h00 : run_reg + 7'h01;
	end
	// line undefined while signal off: stuck high, so a leak looks like a long run
	assign rx_bit_pin = !sig_on ? 1'b1 : fef_mode ? (run_reg != RUN_MAX) : data_bit;
	assign signal_ok_pin = sig_on;
endmodule

// File: tb/test_lmf_link_monitor.sv
`timescale 1ns/1ns
module test_lmf_link_monitor
	import lmf_pkg::*;
;
	localparam int SC = 20;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, r;
	logic hreadyout, hresp, tx_bit_out, rx_bit_out, signal_ok_pin, rx_bit_pin;
	lmf_link_s link_status;
	logic tx_bit_in = 1'b0;
	logic data_bit = 1'b0;
	logic sig_on = 1'b0;
	logic fef_mode = 1'b0;
	logic pass_on = 1'b0;
	logic rx_on = 1'b0;
	logic [2:0] rxh = 3'h0;
	logic txh = 1'b0;
	int seed = 32'h870d;
	int bad_count = 0;
	int comparisons = 0;
	int n;
	always #20 hclk = !hclk;
	lmf_link_monitor #(.STAB_COUNT(SC)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.signal_ok_pin(signal_ok_pin), .rx_bit_pin(rx_bit_pin), .tx_bit_in(tx_bit_in),
		.tx_bit_out(tx_bit_out), .rx_bit_out(rx_bit_out), .link_status(link_status));
	lmf_xcvr_model xcvr (.hclk(hclk), .sig_on(sig_on), .fef_mode(fef_mode),
		.data_bit(data_bit), .signal_ok_pin(signal_ok_pin), .rx_bit_pin(rx_bit_pin));
	////////////////////////////////////////////////////////////////
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	function automatic logic fault_bit(input int i);
		return (i % (FAULT_RUN_LENGTH + 1)) != FAULT_RUN_LENGTH;
	endfunction
	task automatic hang(input string what);
		bad_count++;
		$display("MISMATCH %0t timeout %s", $time, what);
		final_report();
	endtask
	task automatic edge_ready;
		int k;
		k = 0;
		do
		begin
			@(posedge hclk);
			k++;
		end
		while (hreadyout !== 1'b1 && k < 50);
		if (k >= 50)
			hang("bus");
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {20'h0, a};
		edge_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		edge_ready();
		r = hrdata;
		chk(32'(hresp), 32'(HRESP_OKAY), "bus response");
	endtask
	// status wait also counts as a check: reaching it in time is the result
	task automatic wait_st(input logic [2:0] want, input logic [2:0] mask, input int lim);
		comparisons++;
		n = 0;
		while ((link_status & mask) !== (want & mask) && n < lim)
		begin
			@(posedge hclk);
			n++;
		end
		if (n >= lim)
			hang("status");
	endtask
	////////////////////////////////////////////////////////////////
	always @(posedge hclk)
	begin
		tx_bit_in <= 1'($random(seed));
		data_bit <= 1'($random(seed));
		rxh <= {rxh[1:0], rx_bit_pin};
		txh <= tx_bit_in;
		if (rx_on)
			chk(32'(rx_bit_out), 32'(rxh[2]), "rx path");
		if (pass_on)
			chk(32'(tx_bit_out), 32'(txh), "tx pass");
	end
	initial
	begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		chk(32'(link_status), 32'h0, "reset status");
		repeat (4) @(posedge hclk);
		rx_on <= 1'b1;
		bus(1'b0, CTRL_OFS, 32'h0);
		chk(r, CTRL_RESET, "ctrl reset");
		bus(1'b0, 12'h010, 32'h0);
		chk(r, 32'h0, "unmapped read");
		$display("test registers done");
		sig_on <= 1'b1;
		repeat (10) @(posedge hclk);
		sig_on <= 1'b0;
		repeat (3) @(posedge hclk);
		sig_on <= 1'b1;
		@(posedge hclk);
		wait_st({LMF_OK, 1'b0}, 3'h7, SC + 20);
		chk(32'(n >= SC && n <= SC + 8), 32'h1, "qualify time");
		pass_on <= 1'b1;
		repeat (100) @(posedge hclk);
		pass_on <= 1'b0;
		$display("test qualify done");
		bus(1'b1, CTRL_OFS, 32'h5);
		wait_st(3'h0, 3'h6, 6);
		bus(1'b1, CTRL_OFS, 32'h7);
		wait_st({LMF_OK, 1'b0}, 3'h6, SC + 20);
		bus(1'b0, CTRL_OFS, 32'h0);
		chk(r, 32'h7, "ctrl write");
		$display("test gate done");
		sig_on <= 1'b0;
		wait_st(3'h0, 3'h6, 6);
		n = 0;
		while (tx_bit_out !== 1'b0 && n < 100)
		begin
			@(posedge hclk);
			n++;
		end
		if (n >= 100)
			hang("pattern");
		for (int i = 0; i < 170; i++)
		begin
			@(posedge hclk);
			chk(32'(tx_bit_out), 32'(fault_bit(i)), "fault pattern");
		end
		chk(32'(link_status.faulting), 32'h0, "rx off read as zero");
		bus(1'b0, STATUS_OFS, 32'h0);
		chk(r, 32'h0, "status while signal off");
		$display("test pattern done");
		fef_mode <= 1'b1;
		sig_on <= 1'b1;
		@(posedge hclk);
		wait_st(3'h1, 3'h1, 400);
		chk(32'(n >= 245 && n <= 275), 32'h1, "fault after three");
		wait_st(3'h1, 3'h7, 3);
		bus(1'b0, STATUS_OFS, 32'h0);
		chk(32'(r[5:4]), 32'h3, "cycle count");
		chk(32'(r[14:8] <= 7'h54), 32'h1, "ones count");
		fef_mode <= 1'b0;
		wait_st(3'h0, 3'h1, 100);
		$display("test detect done");
		bus(1'b1, CTRL_OFS, 32'h0);
		fef_mode <= 1'b1;
		wait_st({LMF_OK, 1'b0}, 3'h6, SC + 40);
		repeat (300) @(posedge hclk);
		chk(32'(link_status), 32'({LMF_OK, 1'b0}), "fef off");
		$display("test fef off done");
		final_report();
	end
endmodule
